// ===== rtl/interval_timer_regs.vh
// constants for the down-counting interval timer: register indices, field
// positions, reset values and timing counts.
// assumes it is included by bare name from the timer module source.
//
// Summary of operation
// - setting run/stop starts counting next cycle; clearing it halts the counter.
// - restart resumes held count, or loads a constant written while stopped.
// - count writes while running wait for end of count; prescaler writes apply immediately.
// - count high, count low and prescaler reset to all ones.
// - core is a 16-bit down counter behind an 8-bit prescaler.
// - end of count is the counter underflowing past zero.
// - single mode end of count stops, reloads and clears run/stop.
// - continuous mode end of count reloads and keeps counting until stopped.
// - single/continuous select writable anytime, together with run/stop in one write.
// - input section off ignores input modes, counts core clock over four.
// - event mode counts input falling edges; source holds each level eight core clocks.
// - gated mode counts core clock over four only while input is high.
// - triggerable mode counts after run/stop set and then an input falling edge.
// - retriggerable mode restarts from constants on falling edge while running only.
// - oscillator variant counts the oscillator-derived clock in event mode.
// - prescaler source: core clock over four, divided oscillator clock, or input pin.
// - output mode zero drives the output pin high.
// - square wave mode toggles the output pin at each end of count.
// - pwm mode copies the lower output-mode bit to the pin at end of count.
// - interrupt select zero raises request per end of count; one passes external pin.
// - up to four identical timers, four consecutive byte registers each.
// - count byte reads return the live count; writes set the reload constant.
// - prescaler reads return the programmed value, not the live prescaler state.
// - control resets to gated input, interrupt select one (external pin), stopped, output off.
`ifndef INTERVAL_TIMER_REGS_VH
`define INTERVAL_TIMER_REGS_VH

// ====================================================================
// register indices (byte address is four times the index)
`define IT_IDX_COUNT_HIGH 10'h0F0
`define IT_IDX_COUNT_LOW 10'h0F1
`define IT_IDX_PRESCALE 10'h0F2
`define IT_IDX_CONTROL 10'h0F3
`define IT_IDX_STRIDE 10'h004
`define IT_IDX_BLOCK 6'h0F
`define IT_SEL_COUNT_HIGH 2'h0
`define IT_SEL_COUNT_LOW 2'h1
`define IT_SEL_PRESCALE 2'h2
`define IT_SEL_CONTROL 2'h3

// ====================================================================
// control field positions
`define IT_RUN_BIT 7
`define IT_SINGLE_BIT 6
`define IT_INMODE_HI 5
`define IT_INMODE_LO 4
`define IT_INPUT_SECTION_ENABLE_BIT 3
`define IT_INTSEL_BIT 2
`define IT_OUTMODE_HI 1
`define IT_OUTMODE_LO 0

// input modes
`define IT_IN_EVENT 2'h0
`define IT_IN_GATED 2'h1
`define IT_IN_TRIG 2'h2
`define IT_IN_RETRIG 2'h3

// ====================================================================
// reset values
`define IT_RST_COUNT 16'hFFFF
`define IT_RST_PRESCALE 8'hFF
`define IT_RST_CONTROL 8'h14

// ====================================================================
// timing: internal clock is divided by four for the timer time base
`define IT_CORE_DIV 4
`define IT_CORE_DIV_LAST 2'h3

`endif

// ===== rtl/interval_timer.v
// interval timer block: up to four down-counting timers behind an apb slave.
// assumes ref_clk is the internal core clock at 100 MHz, rst_n is a
// synchronous active-low reset, and pins arrive asynchronously.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_regs.vh"

module interval_timer #(
  parameter NUM_TIMERS = 4,
  parameter OSC_DIV = 4,
  parameter [3:0] OSC_VARIANT = 4'h0
) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [NUM_TIMERS-1:0] timer_input_pin,
  input wire oscillator_derived_clock,
  input wire [NUM_TIMERS-1:0] ext_irq_pin,
  output wire [NUM_TIMERS-1:0] timer_output_pin,
  output wire [NUM_TIMERS-1:0] timer_irq
);

  // kept as integers so no parameter value is cut when it meets a narrow field
  localparam integer NUM_C = NUM_TIMERS;
  localparam integer OSC_LAST = OSC_DIV - 1;

  // ==================================================================
  // apb slave decode
  wire [9:0] word_idx;
  wire [1:0] inst_sel;
  wire [1:0] reg_sel;
  wire mapped;
  wire access_wait;
  wire wr_done;
  wire [8*NUM_TIMERS-1:0] rd_all;
  wire [7:0] rd_byte;

  // index F0..FF holds the block; bits 3:2 pick the timer, 1:0 the register
  assign word_idx = paddr[11:2];
  assign inst_sel = word_idx[3:2];
  assign reg_sel = word_idx[1:0];
  assign mapped = (word_idx[9:4] == `IT_IDX_BLOCK) && ({1'b0, inst_sel} < NUM_C);
  assign access_wait = psel & penable & ~pready;
  // a write lands only at the edge where pready is sampled high
  assign wr_done = psel & penable & pready & pwrite & mapped;
  assign rd_byte = rd_all[inst_sel*8 +: 8];

  // one wait state: pready rises in the second access cycle
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access_wait;
      pslverr <= access_wait & ~mapped;
      if (access_wait) begin
        prdata <= (mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  // ==================================================================
  // shared time bases
  reg [1:0] core_div;
  reg quarter_tick;
  reg [2:0] osc_sync;
  reg osc_lvl;
  reg [7:0] osc_cnt;
  reg osc_tick;
  wire osc_agree;

  // core clock over four, as a one-cycle enable pulse
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      core_div <= 2'h0;
      quarter_tick <= 1'b0;
    end else begin
      core_div <= core_div + 2'h1;
      quarter_tick <= (core_div == `IT_CORE_DIV_LAST);
    end
  end

  // oscillator-derived clock: synchronised, filtered, then divided
  assign osc_agree = (osc_sync[1] == osc_sync[2]);
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      osc_sync <= 3'h0;
      osc_lvl <= 1'b0;
      osc_cnt <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      osc_sync <= {osc_sync[1:0], oscillator_derived_clock};
      osc_tick <= 1'b0;
      if (osc_agree) begin
        osc_lvl <= osc_sync[2];
      end
      // count rising edges; the divider models the device-dependent ratio
      if (osc_agree && osc_sync[2] && !osc_lvl) begin
        if (osc_cnt >= OSC_LAST) begin
          osc_cnt <= 8'h00;
          osc_tick <= 1'b1;
        end else begin
          osc_cnt <= osc_cnt + 8'h01;
        end
      end
    end
  end

  // ==================================================================
  // timer instances
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TIMERS; gi = gi + 1) begin : g_timer
      reg [7:0] ctrl;
      reg [15:0] reload;
      reg [7:0] pconst;
      reg [15:0] count;
      reg [7:0] pcount;
      reg pending;
      reg armed;
      reg was_run;
      reg out_q;
      reg irq_q;
      reg [2:0] in_sync;
      reg in_lvl;
      reg [2:0] ext_sync;
      reg ext_lvl;
      reg tick;
      reg [7:0] rd_q;
      wire wr_here;
      wire wr_high;
      wire wr_low;
      wire wr_presc;
      wire wr_ctrl;
      wire run;
      wire in_en;
      wire [1:0] in_mode;
      wire [1:0] out_mode;
      wire in_fall;
      wire start;
      wire retrig;
      wire reload_now;
      wire step;
      wire eoc;

      assign wr_here = wr_done && (inst_sel == gi);
      assign wr_high = wr_here && (reg_sel == `IT_SEL_COUNT_HIGH);
      assign wr_low = wr_here && (reg_sel == `IT_SEL_COUNT_LOW);
      assign wr_presc = wr_here && (reg_sel == `IT_SEL_PRESCALE);
      assign wr_ctrl = wr_here && (reg_sel == `IT_SEL_CONTROL);

      // control field view
      assign run = ctrl[`IT_RUN_BIT];
      assign in_en = ctrl[`IT_INPUT_SECTION_ENABLE_BIT];
      assign in_mode = ctrl[`IT_INMODE_HI:`IT_INMODE_LO];
      assign out_mode = ctrl[`IT_OUTMODE_HI:`IT_OUTMODE_LO];

      // pin synchronisers; the filtered level moves once flops two and three agree
      assign in_fall = (in_sync[1] == in_sync[2]) && in_lvl && !in_sync[2];
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          in_sync <= 3'h7;
          in_lvl <= 1'b1;
          ext_sync <= 3'h0;
          ext_lvl <= 1'b0;
        end else begin
          in_sync <= {in_sync[1:0], timer_input_pin[gi]};
          ext_sync <= {ext_sync[1:0], ext_irq_pin[gi]};
          if (in_sync[1] == in_sync[2]) begin
            in_lvl <= in_sync[2];
          end
          if (ext_sync[1] == ext_sync[2]) begin
            ext_lvl <= ext_sync[2];
          end
        end
      end

      // prescaler clock source per input mode
      always @* begin
        tick = 1'b0;
        if (!in_en) begin
          tick = quarter_tick;
        end else begin
          case (in_mode)
            `IT_IN_EVENT: tick = OSC_VARIANT[gi] ? osc_tick : in_fall;
            `IT_IN_GATED: tick = quarter_tick & in_lvl;
            `IT_IN_TRIG: tick = quarter_tick & armed;
            `IT_IN_RETRIG: tick = quarter_tick;
            default: tick = 1'b0;
          endcase
        end
      end

      // the cycle after run/stop rises is the first counting cycle
      assign start = run & ~was_run;
      assign retrig = run & in_en & (in_mode == `IT_IN_RETRIG) & in_fall;
      assign reload_now = (start & pending) | retrig;
      assign step = run & ~reload_now & tick;
      assign eoc = step && (pcount == 8'h00) && (count == 16'h0000);

      // triggerable mode waits for a falling edge after run/stop is set
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          armed <= 1'b0;
          was_run <= 1'b0;
        end else begin
          was_run <= run;
          if (!run) begin
            armed <= 1'b0;
          end else if (in_en && (in_mode == `IT_IN_TRIG) && in_fall) begin
            armed <= 1'b1;
          end
        end
      end

      // counter, prescaler and reload constants
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          reload <= `IT_RST_COUNT;
          pconst <= `IT_RST_PRESCALE;
          count <= `IT_RST_COUNT;
          pcount <= `IT_RST_PRESCALE;
          pending <= 1'b0;
        end else begin
          if (reload_now) begin
            count <= reload;
            pcount <= pconst;
            pending <= 1'b0;
          end else if (step) begin
            // prescaler divides by its value plus one, then steps the counter
            if (pcount == 8'h00) begin
              pcount <= pconst;
              if (count == 16'h0000) begin
                count <= reload;
                pending <= 1'b0;
              end else begin
                count <= count - 16'h0001;
              end
            end else begin
              pcount <= pcount - 8'h01;
            end
          end
          // software writes come last so a set of pending beats its clear
          if (wr_high) begin
            reload[15:8] <= pwdata[7:0];
            pending <= 1'b1;
          end
          if (wr_low) begin
            reload[7:0] <= pwdata[7:0];
            pending <= 1'b1;
          end
          if (wr_presc) begin
            pconst <= pwdata[7:0];
            if (run) begin
              pcount <= pwdata[7:0];
            end else begin
              pending <= 1'b1;
            end
          end
        end
      end

      // control: single mode clears run/stop at end of count; a software write
      // in the same cycle wins so a fresh start is never lost
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          ctrl <= `IT_RST_CONTROL;
        end else if (wr_ctrl) begin
          ctrl <= pwdata[7:0];
        end else if (eoc && ctrl[`IT_SINGLE_BIT]) begin
          ctrl[`IT_RUN_BIT] <= 1'b0;
        end
      end

      // output pin and interrupt channel
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          out_q <= 1'b1;
          irq_q <= 1'b0;
        end else begin
          if (out_mode == 2'h0) begin
            out_q <= 1'b1;
          end else if (eoc) begin
            if (out_mode[1]) begin
              out_q <= out_mode[0];
            end else begin
              out_q <= ~out_q;
            end
          end
          // with interrupt select zero the request is a one-cycle pulse per end of count
          irq_q <= ctrl[`IT_INTSEL_BIT] ? ext_lvl : eoc;
        end
      end

      // read view: live count, programmed prescaler, control
      always @* begin
        case (reg_sel)
          `IT_SEL_COUNT_HIGH: rd_q = count[15:8];
          `IT_SEL_COUNT_LOW: rd_q = count[7:0];
          `IT_SEL_PRESCALE: rd_q = pconst;
          `IT_SEL_CONTROL: rd_q = ctrl;
          default: rd_q = 8'h00;
        endcase
      end

      assign rd_all[gi*8 +: 8] = rd_q;
      assign timer_output_pin[gi] = out_q;
      assign timer_irq[gi] = irq_q;
    end
  endgenerate

endmodule // interval_timer
`default_nettype wire

// ===== tb/interval_timer_checker.sv
// checker: apb answer timing and pin relations of the interval timer.
// assumes it is bound to each interval_timer; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module interval_timer_checker #(parameter NUM_TIMERS = 4) (
  input wire ref_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NUM_TIMERS-1:0] timer_input_pin,
  input wire oscillator_derived_clock,
  input wire [NUM_TIMERS-1:0] ext_irq_pin,
  input wire [NUM_TIMERS-1:0] timer_output_pin,
  input wire [NUM_TIMERS-1:0] timer_irq
);
  // ====================================================================
  // decode helpers: four byte registers per timer from 3C0h
  wire acc = psel && penable && !pready;
  wire mapped = paddr >= 12'h3C0 && paddr < 12'h3C0 + 12'h010 * NUM_TIMERS;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ====================================================================
  // assertions
  a_ready_follows: assert property (acc |=> pready)
    else $error("ready missing after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_error_unmapped: assert property (acc && !mapped |=> pslverr)
    else $error("no error on unmapped address");
  a_error_mapped: assert property (acc && mapped |=> !pslverr)
    else $error("error on mapped address");
  a_error_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_byte_wide_data: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_pins_high_reset: assert property ($rose(rst_n) |-> &timer_output_pin)
    else $error("output pin low after reset");
  // main scenarios
  c_write: cover property (acc && pwrite);
  c_unmapped: cover property (acc && !mapped);
  c_irq: cover property (timer_irq[0]);
  c_pin_low: cover property (!timer_output_pin[0]);
endmodule // interval_timer_checker
bind interval_timer interval_timer_checker #(.NUM_TIMERS(NUM_TIMERS)) u_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_input_pin(timer_input_pin), .oscillator_derived_clock(oscillator_derived_clock),
  .ext_irq_pin(ext_irq_pin), .timer_output_pin(timer_output_pin), .timer_irq(timer_irq));
`default_nettype wire

// ===== tb/timer_pin_model.sv
// model of the source that drives the timer input pin.
// assumes fall_req is a one-cycle request from the bench.
`timescale 1ns/1ps
`default_nettype none
module timer_pin_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fall_req,
  input wire logic idle_level,
  output logic pin,
  output logic busy
);
  logic [4:0] cnt;
  // each request: 8 cycles low, 8 high, so falls are at least 17 clocks apart
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      cnt <= 5'h00;
    else if (fall_req && cnt == 5'h00)
      cnt <= 5'h10;
    else if (cnt != 5'h00)
      cnt <= cnt - 5'h01;
  end
  assign busy = (cnt != 5'h00);
  assign pin = busy ? (cnt <= 5'h08) : idle_level;
endmodule // timer_pin_model
`default_nettype wire

// ===== tb/interval_timer_test.sv
// testbench of the interval timer: apb master, pin model, scenarios.
// assumes two timers, oscillator input unused.
`timescale 1ns/1ps
`default_nettype none
module interval_timer_test;
  localparam logic [11:0] H0 = 12'h3C0;
  localparam logic [11:0] L0 = 12'h3C4;
  localparam logic [11:0] P0 = 12'h3C8;
  localparam logic [11:0] C0 = 12'h3CC;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] ext_irq_pin = 2'h0;
  logic fall_req = 1'b0;
  logic idle_level = 1'b1;
  logic [31:0] prdata, rdq, keep;
  logic pready, pslverr, rde, pin, busy, p;
  logic [1:0] timer_output_pin, timer_irq;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  int gap;
  int cyc = 0;
  int last_irq = 0;
  interval_timer #(.NUM_TIMERS(2), .OSC_DIV(1)) u_interval_timer (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_pin({2{pin}}), .oscillator_derived_clock(1'b0),
    .ext_irq_pin(ext_irq_pin), .timer_output_pin(timer_output_pin), .timer_irq(timer_irq));
  timer_pin_model u_timer_pin_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .fall_req(fall_req), .idle_level(idle_level), .pin(pin), .busy(busy));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // free-running cycle count, used to measure spacing between irq edges
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
  end
  // ====================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // request is held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // a bus that never answers counts as a mismatch
    if (pready !== 1'b1) miscompares++;
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdq, {24'h0, exp});
  endtask
  // n is the wait length; gap the cycles since the previous irq edge
  task automatic wait_irq();
    n = 0;
    @(posedge ref_clk);
    while (timer_irq[0] !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400) miscompares++;
    gap = cyc - last_irq;
    last_irq = cyc;
  endtask
  task automatic falls(input int cnt);
    repeat (cnt) begin
      @(posedge ref_clk);
      fall_req <= 1'b1;
      @(posedge ref_clk);
      fall_req <= 1'b0;
      repeat (20) @(posedge ref_clk);
    end
  endtask
  // ====================================================================
  // scenarios
  task automatic s_reset();
    rd(H0, 8'hFF);
    rd(L0, 8'hFF);
    rd(P0, 8'hFF);
    rd(C0, 8'h14);
    check(timer_output_pin, 2'h3);
  endtask
  task automatic s_map();
    apb(1'b0, 12'h3E0, 32'h0);
    check(rde, 1'b1);
    check(rdq, 32'h0);
    wr(12'h3D8, 8'h5A);
    rd(12'h3D8, 8'h5A);
    rd(P0, 8'hFF);
  endtask
  task automatic s_single();
    wr(P0, 8'h00);
    wr(L0, 8'h03);
    wr(H0, 8'h00);
    wr(C0, 8'hC1);
    p = timer_output_pin[0];
    wait_irq();
    check(timer_output_pin[0], {31'h0, ~p});
    @(posedge ref_clk);
    check(timer_irq[0], 1'b0);
    rd(C0, 8'h41);
    rd(L0, 8'h03);
  endtask
  task automatic s_continuous();
    wr(P0, 8'h01);
    wr(L0, 8'h01);
    wr(C0, 8'h81);
    wait_irq();
    wait_irq();
    check(gap, 16);
    wr(L0, 8'h05);
    wait_irq();
    check(gap, 16);
    wait_irq();
    check(gap, 48);
    // four toggles leave the pin low, so drive it high first, then low
    wr(C0, 8'h83);
    wait_irq();
    check(timer_output_pin[0], 1'b1);
    wr(C0, 8'h82);
    wait_irq();
    check(timer_output_pin[0], 1'b0);
    wr(C0, 8'h03);
    apb(1'b0, L0, 32'h0);
    keep = rdq;
    repeat (30) @(posedge ref_clk);
    rd(L0, keep[7:0]);
  endtask
  task automatic s_irq_select();
    wr(C0, 8'h04);
    ext_irq_pin <= 2'h1;
    repeat (8) @(posedge ref_clk);
    check(timer_irq[0], 1'b1);
    ext_irq_pin <= 2'h0;
    repeat (8) @(posedge ref_clk);
    check(timer_irq[0], 1'b0);
  endtask
  task automatic s_inputs();
    wr(P0, 8'h00);
    wr(L0, 8'h01);
    wr(C0, 8'h88);
    falls(1);
    check(timer_irq[0], 1'b0);
    rd(L0, 8'h00);
    fork
      falls(1);
      wait_irq();
    join
    check(n < 20, 1'b1);
    wr(C0, 8'h18);
    idle_level <= 1'b0;
    wr(L0, 8'h20);
    wr(C0, 8'h98);
    repeat (40) @(posedge ref_clk);
    rd(L0, 8'h20);
    wr(C0, 8'hA8);
    idle_level <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rd(L0, 8'h20);
    fork
      falls(1);
      wait_irq();
    join
    check(n < 160, 1'b1);
  endtask
  // retrigger restarts from the constant while running, is ignored while stopped
  task automatic s_retrig();
    wr(C0, 8'h38);
    wr(L0, 8'h40);
    wr(C0, 8'hB8);
    repeat (100) @(posedge ref_clk);
    falls(1);
    apb(1'b0, L0, 32'h0);
    check(rdq[7:0] >= 8'h38, 1'b1);
    wr(C0, 8'h38);
    apb(1'b0, L0, 32'h0);
    keep = rdq;
    falls(1);
    rd(L0, keep[7:0]);
  endtask
  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog sized far above the thousand or so cycles the scenarios need
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_reset();
    s_map();
    s_single();
    s_continuous();
    s_irq_select();
    s_inputs();
    s_retrig();
    give_verdict();
  end
endmodule // interval_timer_test
`default_nettype wire
